// ---- hw/cevp_pkg.sv ----
// package: constants for the channel event, power and semaphore block
package cevp_pkg;
    localparam int NUM_CH    = 2;
    localparam int NUM_RXBUF = 16;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // ****************************************************
    // register offsets (byte addresses, channel stride)
    // ****************************************************
    localparam logic [7:0] CH_STRIDE        = 8'h40;
    localparam logic [7:0] OFS_CTRL         = 8'h00;
    localparam logic [7:0] OFS_ERR_STATUS   = 8'h04;
    localparam logic [7:0] OFS_TX_CTRL      = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h0C;
    localparam logic [7:0] OFS_RX_DATA_NEW  = 8'h10;
    localparam logic [7:0] OFS_RX_MEM_UPD   = 8'h14;
    localparam logic [7:0] OFS_CONFIG       = 8'h18;
    localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h1C;

    // ****************************************************
    // control register fields
    // ****************************************************
    localparam int CTRL_INIT     = 0;
    localparam int CTRL_SLEEP    = 1;
    localparam int CTRL_STOPSEL  = 2;
    localparam int CTRL_INITCONF = 3;
    localparam int CTRL_PWR_LSB  = 4;

    // error status fields
    localparam int ES_BUS_OFF_STATE = 0;
    localparam int ES_TX_ERROR_STATUS = 1;
    localparam int ES_RX_ERROR_STATUS = 2;
    localparam int ES_OVER = 3;
    localparam int ES_WAKE = 4;

    // tx control fields
    localparam int TX_REQ0   = 0;
    localparam int TX_REQ1   = 1;
    localparam int TX_ABORT0 = 2;
    localparam int TX_ABORT1 = 3;

    // irq flag fields
    localparam int IF_ERR = 0;
    localparam int IF_RX  = 1;
    localparam int IF_TX0 = 2;
    localparam int IF_TX1 = 3;

    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam int          CONFIG_W     = 32;

    typedef enum logic [3:0] {
        CEVP_PWR_NORMAL = 4'h1,
        CEVP_PWR_SLEEP  = 4'h2,
        CEVP_PWR_STOP   = 4'h4,
        CEVP_PWR_RESYNC = 4'h8
    } cevp_pwr_t;

    // recessive bits needed to resynchronise after wake
    localparam int RESYNC_BITS = 11;
endpackage

// ---- hw/cevp_sync.sv ----
// three-stage synchroniser with agreement filter
module cevp_sync
    import cevp_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic lvl_d;

    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s1_q  <= RESET_VAL;
            s2_q  <= RESET_VAL;
            s3_q  <= RESET_VAL;
            lvl_q <= RESET_VAL;
        end else begin
            s1_q  <= i_async;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;
endmodule // cevp_sync

// ---- hw/cevp_channel.sv ----
// per-channel event, power-mode and transmit request logic
module cevp_channel
    import cevp_pkg::*;
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_srst,
    input  wire logic                 i_rx_level,
    input  wire logic                 i_bit_tick,
    input  wire logic                 i_bus_idle,
    input  wire logic                 i_clk_restart,
    input  wire logic                 i_init_req,
    input  wire logic                 i_sleep_req,
    input  wire logic                 i_stop_sel,
    input  wire logic                 i_wake_clr,
    input  wire logic [1:0]           i_txreq_set,
    input  wire logic [1:0]           i_txabort_set,
    input  wire logic [1:0]           i_tx_done,
    input  wire logic [3:0]           i_err_state,
    input  wire logic                 i_overrun,
    input  wire logic                 i_rx_stored,
    output logic [1:0]                o_txreq,
    output logic [1:0]                o_txabort,
    output logic [1:0]                o_tx_irq,
    output logic                      o_err_irq,
    output logic                      o_err_pulse,
    output logic                      o_wake,
    output logic                      o_over,
    output cevp_pwr_t                 o_pwr,
    output logic                      o_online
);
    cevp_pwr_t  pwr_q, pwr_d;
    logic [1:0] txreq_q, txreq_d, txab_q, txab_d, txirq_q, txirq_d;
    logic [3:0] errst_q;
    logic       wake_q, wake_d, over_q, over_d, epulse_q, epulse_d;
    logic [4:0] rcnt_q, rcnt_d;
    logic       rx_dom;

    assign rx_dom = !i_rx_level;

    always_comb begin
        pwr_d   = pwr_q;
        wake_d  = wake_q;
        over_d  = over_q;
        rcnt_d  = rcnt_q;
        txreq_d = txreq_q;
        txab_d  = txab_q;
        txirq_d = 2'h0;
        // tx request cleared only here, after success or abort
        for (int b = 0; b < 2; b++) begin
            if (i_txreq_set[b] && !txreq_q[b]) txreq_d[b] = 1'b1;
            if (i_txabort_set[b] && txreq_q[b]) txab_d[b] = 1'b1;
            if (txreq_q[b] && (i_tx_done[b] || txab_q[b])) begin
                txreq_d[b] = 1'b0;
                txab_d[b]  = 1'b0;
                txirq_d[b] = 1'b1;
            end
        end
        if (i_clk_restart || i_overrun) over_d = 1'b1;
        if (i_wake_clr) wake_d = 1'b0;
        unique case (pwr_q)
            CEVP_PWR_NORMAL: begin
                if (i_sleep_req && !i_init_req && !wake_q) begin
                    if (i_bus_idle) begin
                        pwr_d = i_stop_sel ? CEVP_PWR_STOP : CEVP_PWR_SLEEP;
                    end else begin
                        wake_d = 1'b1; // refused, busy bus
                    end
                end
            end
            CEVP_PWR_SLEEP: begin
                if (rx_dom) begin
                    pwr_d  = CEVP_PWR_RESYNC;
                    wake_d = 1'b1;
                end else if (!i_sleep_req) begin
                    pwr_d = CEVP_PWR_NORMAL;
                end
            end
            CEVP_PWR_STOP: begin
                if (!i_sleep_req) pwr_d = CEVP_PWR_NORMAL;
            end
            CEVP_PWR_RESYNC: begin
                if (rx_dom) begin
                    rcnt_d = 5'h00;
                end else if (i_bit_tick) begin
                    rcnt_d = rcnt_q + 5'h01;
                end
                if (rcnt_q == 5'(RESYNC_BITS)) begin
                    pwr_d  = CEVP_PWR_NORMAL;
                    rcnt_d = 5'h00;
                end
            end
            default: pwr_d = CEVP_PWR_NORMAL;
        endcase
        // error event on status changes or rising overrun/wake
        epulse_d = (i_err_state != errst_q) || (over_d && !over_q) ||
                   (wake_d && !wake_q);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pwr_q    <= CEVP_PWR_NORMAL;
            wake_q   <= 1'b0;
            over_q   <= 1'b0;
            rcnt_q   <= 5'h00;
            txreq_q  <= 2'h0;
            txab_q   <= 2'h0;
            txirq_q  <= 2'h0;
            errst_q  <= 4'h0;
            epulse_q <= 1'b0;
        end else begin
            pwr_q    <= pwr_d;
            wake_q   <= wake_d;
            over_q   <= over_d;
            rcnt_q   <= rcnt_d;
            txreq_q  <= txreq_d;
            txab_q   <= txab_d;
            txirq_q  <= txirq_d;
            errst_q  <= i_err_state;
            epulse_q <= epulse_d;
        end
    end

    assign o_txreq     = txreq_q;
    assign o_txabort   = txab_q;
    assign o_tx_irq    = txirq_q;
    assign o_err_pulse = epulse_q;
    assign o_err_irq   = wake_q | epulse_q;
    assign o_wake      = wake_q;
    assign o_over      = over_q;
    assign o_pwr       = pwr_q;
    assign o_online    = (pwr_q == CEVP_PWR_NORMAL) && !i_init_req;
endmodule // cevp_channel

// ---- hw/cevp_top.sv ----
// top: two-channel event, power and receive-semaphore block with register port
// Summary of operation
// - each channel has error, receive and two transmit interrupt outputs
// - transmit interrupt n fires when buffer n request bit clears
// - request clears after success or abort and frees the buffer
// - only the block clears requests; software sets abort instead
// - receive interrupt needs valid frame, match, stored data, buffer enable
// - receive interrupt may lag up to seventh bit of next frame
// - error interrupt on bus-off, tx/rx status change, first overrun after reset, wake
// - wake holds the interrupt high until software clears wake
// - after clock supply returns the block flags overrun
// - sleep request refused on a busy bus by setting the wake flag; a grant shows only in the power mode
// - sleep left on bus activity, detected through the clocked synchroniser
// - after wake the block resynchronises to the bus
// - stop mode uses the sleep handshake with wake answer
// - stop left only by software clearing the sleep request
// - configuration writes blocked once init request is cleared
// - storing sets data-new and memory-update, clears update when stable
// - mask setting readable always, writable only in confirmed init
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
module cevp_top
    import cevp_pkg::*;
(
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_srst,
    input  wire logic [ADDR_W-1:0]          i_addr,
    input  wire logic [DATA_W-1:0]          i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [DATA_W-1:0]          o_rdata,
    input  wire logic [NUM_CH-1:0]          i_can_rx,
    input  wire logic [NUM_CH-1:0]          i_bit_tick,
    input  wire logic [NUM_CH-1:0]          i_bus_idle,
    input  wire logic [NUM_CH-1:0]          i_clk_restart,
    input  wire logic [NUM_CH-1:0]          i_init_active,
    input  wire logic [NUM_CH*2-1:0]        i_tx_done,
    input  wire logic [NUM_CH*4-1:0]        i_err_state,
    input  wire logic [NUM_CH-1:0]          i_overrun,
    input  wire logic [NUM_CH-1:0]          i_frame_valid,
    input  wire logic [NUM_CH-1:0]          i_id_match,
    input  wire logic [NUM_CH*4-1:0]        i_match_buf,
    input  wire logic [NUM_CH-1:0]          i_store_start,
    input  wire logic [NUM_CH-1:0]          i_store_done,
    output logic      [NUM_CH-1:0]          o_err_irq,
    output logic      [NUM_CH-1:0]          o_rx_irq,
    output logic      [NUM_CH-1:0]          o_tx0_irq,
    output logic      [NUM_CH-1:0]          o_tx1_irq,
    output logic      [NUM_CH*2-1:0]        o_tx_request,
    output logic      [NUM_CH-1:0]          o_online,
    output logic      [NUM_CH*CONFIG_W-1:0] o_config
);
    // ****************************************************
    // address decode
    // ****************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input int ch,
                                 input logic [7:0] ofs);
        hit = (a == ADDR_W'(ch * CH_STRIDE + ofs));
    endfunction

    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [NUM_CH-1:0] init_q, init_d, sleep_q, sleep_d, stop_q, stop_d;
    logic [15:0]       ien_q [NUM_CH], ien_d [NUM_CH];
    logic [15:0]       dn_q  [NUM_CH], dn_d  [NUM_CH];
    logic [15:0]       muc_q [NUM_CH], muc_d [NUM_CH];
    logic [CONFIG_W-1:0] cfg_q [NUM_CH], cfg_d [NUM_CH];
    logic [NUM_CH-1:0] rxirq_q, rxirq_d;
    logic [NUM_CH-1:0] storing_q, storing_d;
    logic [3:0]        sbuf_q [NUM_CH], sbuf_d [NUM_CH];
    logic [NUM_CH-1:0] rx_lvl, wake_clr, wake, over;
    logic [1:0]        txreq_set [NUM_CH], txab_set [NUM_CH], txreq [NUM_CH];
    logic [1:0]        txab [NUM_CH], txirq [NUM_CH];
    logic [NUM_CH-1:0] err_pulse;
    cevp_pwr_t         pwr [NUM_CH];

    // ****************************************************
    // channel instances
    // ****************************************************
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        cevp_sync #(.RESET_VAL(1'b1)) u_sync (
            .i_ref_clk (i_ref_clk),
            .i_srst    (i_srst),
            .i_async   (i_can_rx[c]),
            .o_level   (rx_lvl[c])
        );

        assign wake_clr[c]  = i_wr && hit(i_addr, c, OFS_ERR_STATUS) && i_wdata[ES_WAKE];
        assign txreq_set[c] = (i_wr && hit(i_addr, c, OFS_TX_CTRL)) ?
                              i_wdata[TX_REQ1:TX_REQ0] : 2'h0;
        assign txab_set[c]  = (i_wr && hit(i_addr, c, OFS_TX_CTRL)) ?
                              i_wdata[TX_ABORT1:TX_ABORT0] : 2'h0;

        cevp_channel u_chan (
            .i_ref_clk     (i_ref_clk),
            .i_srst        (i_srst),
            .i_rx_level    (rx_lvl[c]),
            .i_bit_tick    (i_bit_tick[c]),
            .i_bus_idle    (i_bus_idle[c]),
            .i_clk_restart (i_clk_restart[c]),
            .i_init_req    (init_q[c]),
            .i_sleep_req   (sleep_q[c]),
            .i_stop_sel    (stop_q[c]),
            .i_wake_clr    (wake_clr[c]),
            .i_txreq_set   (txreq_set[c]),
            .i_txabort_set (txab_set[c]),
            .i_tx_done     (i_tx_done[c*2 +: 2]),
            .i_err_state   (i_err_state[c*4 +: 4]),
            .i_overrun     (i_overrun[c]),
            .i_rx_stored   (i_store_done[c]),
            .o_txreq       (txreq[c]),
            .o_txabort     (txab[c]),
            .o_tx_irq      (txirq[c]),
            .o_err_irq     (o_err_irq[c]),
            .o_err_pulse   (err_pulse[c]),
            .o_wake        (wake[c]),
            .o_over        (over[c]),
            .o_pwr         (pwr[c]),
            .o_online      (o_online[c])
        );

        assign o_tx0_irq[c]           = txirq[c][0];
        assign o_tx1_irq[c]           = txirq[c][1];
        assign o_rx_irq[c]            = rxirq_q[c];
        assign o_tx_request[c*2 +: 2] = txreq[c];
        assign o_config[c*CONFIG_W +: CONFIG_W] = cfg_q[c];
    end

    // ****************************************************
    // control, semaphores and receive interrupt
    // ****************************************************
    always_comb begin
        init_d    = init_q;
        sleep_d   = sleep_q;
        stop_d    = stop_q;
        rxirq_d   = '0;
        storing_d = storing_q;
        for (int c = 0; c < NUM_CH; c++) begin
            ien_d[c]  = ien_q[c];
            dn_d[c]   = dn_q[c];
            muc_d[c]  = muc_q[c];
            cfg_d[c]  = cfg_q[c];
            sbuf_d[c] = sbuf_q[c];
            if (i_wr && hit(i_addr, c, OFS_CTRL)) begin
                init_d[c]  = i_wdata[CTRL_INIT];
                sleep_d[c] = i_wdata[CTRL_SLEEP];
                stop_d[c]  = i_wdata[CTRL_STOPSEL];
            end
            if (i_wr && hit(i_addr, c, OFS_IRQ_ENABLE)) ien_d[c] = i_wdata[15:0];
            // config locked unless init requested and confirmed
            if (i_wr && hit(i_addr, c, OFS_CONFIG) && init_q[c] && i_init_active[c]) begin
                cfg_d[c] = i_wdata[CONFIG_W-1:0];
            end
            // software clear of data-new also clears memory-update
            if (i_wr && hit(i_addr, c, OFS_RX_DATA_NEW)) begin
                dn_d[c]  = dn_q[c] & ~i_wdata[15:0];
                muc_d[c] = muc_q[c] & ~i_wdata[15:0];
            end
            if (i_store_start[c] && i_frame_valid[c] && i_id_match[c]) begin
                storing_d[c]            = 1'b1;
                sbuf_d[c]               = i_match_buf[c*4 +: 4];
                dn_d[c][sbuf_d[c]]      = 1'b1;
                muc_d[c][sbuf_d[c]]     = 1'b1;
            end else if (storing_q[c]) begin
                muc_d[c][sbuf_q[c]] = 1'b1; // set wins over clear
                if (i_store_done[c]) begin
                    storing_d[c]        = 1'b0;
                    muc_d[c][sbuf_q[c]] = 1'b0;
                    rxirq_d[c]          = ien_q[c][sbuf_q[c]];
                end
            end
        end
        rdata_d = '0;
        if (i_rd) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (hit(i_addr, c, OFS_CTRL)) begin
                    rdata_d = {24'h0, 4'(pwr[c]), i_init_active[c] & init_q[c],
                               stop_q[c], sleep_q[c], init_q[c]};
                end
                if (hit(i_addr, c, OFS_ERR_STATUS)) begin
                    rdata_d = {27'h0, wake[c], over[c], i_err_state[c*4+2 -: 3]};
                end
                if (hit(i_addr, c, OFS_TX_CTRL)) rdata_d = {28'h0, txab[c], txreq[c]};
                if (hit(i_addr, c, OFS_IRQ_ENABLE)) rdata_d = {16'h0, ien_q[c]};
                if (hit(i_addr, c, OFS_RX_DATA_NEW)) rdata_d = {16'h0, dn_q[c]};
                if (hit(i_addr, c, OFS_RX_MEM_UPD)) rdata_d = {16'h0, muc_q[c]};
                if (hit(i_addr, c, OFS_CONFIG)) rdata_d = cfg_q[c];
                if (hit(i_addr, c, OFS_IRQ_FLAGS)) begin
                    rdata_d = {28'h0, txirq[c], rxirq_q[c], err_pulse[c] | wake[c]};
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            init_d_reset: begin
                init_q    <= '1;
                sleep_q   <= '0;
                stop_q    <= '0;
                rxirq_q   <= '0;
                storing_q <= '0;
                rdata_q   <= '0;
                for (int c = 0; c < NUM_CH; c++) begin
                    ien_q[c]  <= 16'h0000;
                    dn_q[c]   <= 16'h0000;
                    muc_q[c]  <= 16'h0000;
                    cfg_q[c]  <= CONFIG_RESET;
                    sbuf_q[c] <= 4'h0;
                end
            end
        end else begin
            init_q    <= init_d;
            sleep_q   <= sleep_d;
            stop_q    <= stop_d;
            rxirq_q   <= rxirq_d;
            storing_q <= storing_d;
            rdata_q   <= rdata_d;
            for (int c = 0; c < NUM_CH; c++) begin
                ien_q[c]  <= ien_d[c];
                dn_q[c]   <= dn_d[c];
                muc_q[c]  <= muc_d[c];
                cfg_q[c]  <= cfg_d[c];
                sbuf_q[c] <= sbuf_d[c];
            end
        end
    end

    assign o_rdata = rdata_q;
endmodule // cevp_top

// ---- testbench/cevp_monitor.sv ----
// checker: port-level timing of interrupts and transmit requests
module cevp_monitor
    import cevp_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_srst,
    input wire logic              i_wr,
    input wire logic [NUM_CH-1:0] i_clk_restart,
    input wire logic [NUM_CH*4-1:0] i_err_state,
    input wire logic [NUM_CH-1:0] i_store_done,
    input wire logic [NUM_CH-1:0] o_err_irq,
    input wire logic [NUM_CH-1:0] o_rx_irq,
    input wire logic [NUM_CH-1:0] o_tx0_irq,
    input wire logic [NUM_CH-1:0] o_tx1_irq,
    input wire logic [NUM_CH*2-1:0] o_tx_request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    a_tx0_after_clear: assert property ($fell(o_tx_request[0]) |-> o_tx0_irq[0])
        else $error("tx0 interrupt missing after request clear");
    a_tx1_after_clear: assert property ($fell(o_tx_request[1]) |-> o_tx1_irq[0])
        else $error("tx1 interrupt missing after request clear");
    a_tx0_has_cause: assert property (o_tx0_irq[0] |->
        $past(o_tx_request[0]) && !o_tx_request[0])
        else $error("tx0 interrupt without request clear");
    a_tx_single_pulse: assert property (o_tx1_irq[0] |=> !o_tx1_irq[0])
        else $error("tx1 interrupt longer than one cycle");
    a_rx_needs_store: assert property (o_rx_irq[0] |-> $past(i_store_done[0]))
        else $error("receive interrupt without completed store");
    a_rx_single_pulse: assert property (o_rx_irq[0] |=> !o_rx_irq[0])
        else $error("receive interrupt longer than one cycle");
    a_req_set_by_write: assert property ($rose(o_tx_request[0]) |-> $past(i_wr))
        else $error("transmit request set without a write");
    a_err_on_status: assert property ($changed(i_err_state[3:0]) |-> ##[1:3] o_err_irq[0])
        else $error("error interrupt missing after status change");
    a_err_on_restart: assert property (i_clk_restart[0] |-> ##[1:4] o_err_irq[0])
        else $error("error interrupt missing after clock restart");

    c_tx_clear: cover property ($fell(o_tx_request[0]));
    c_rx_irq: cover property (o_rx_irq[0]);
    c_err_rise: cover property ($rose(o_err_irq[0]));
endmodule // cevp_monitor

bind cevp_top cevp_monitor cevp_monitor_inst (.i_ref_clk, .i_srst, .i_wr, .i_clk_restart,
    .i_err_state, .i_store_done, .o_err_irq, .o_rx_irq, .o_tx0_irq, .o_tx1_irq, .o_tx_request);

// ---- testbench/cevp_bus_model.sv ----
// bus-side partner: receive level, bit-time ticks and idle indication
module cevp_bus_model (
    input  wire logic i_ref_clk,
    input  wire logic i_dominant,
    output logic      o_can_rx = 1'b1,
    output logic      o_bit_tick = 1'b0,
    output logic      o_bus_idle = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q = 2'h0;
    always @(posedge i_ref_clk) begin
        div_q <= div_q + 2'h1;
        o_bit_tick <= (div_q == 2'h3); // bit time every four clocks
        o_can_rx <= ~i_dominant;       // dominant level is low
        o_bus_idle <= ~i_dominant;     // busy while dominant
    end
endmodule // cevp_bus_model

// ---- testbench/testbench.sv ----
// testbench: register table, transmit, receive, error and power tests
module testbench
    import cevp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        dom = 1'b0;
    logic        rx_lvl, tick_b, idle;
    logic [1:0]  i_clk_restart = 2'h0, i_init_active = 2'h3, i_overrun = 2'h0;
    logic [1:0]  i_frame_valid = 2'h1, i_id_match = 2'h3;
    logic [1:0]  i_store_start = 2'h0, i_store_done = 2'h0;
    logic [3:0]  i_tx_done = 4'h0;
    logic [7:0]  i_err_state = 8'h00, i_match_buf = 8'h00;
    logic [31:0] o_rdata;
    logic [1:0]  o_err_irq, o_rx_irq, o_tx0_irq, o_tx1_irq, o_online;
    logic [3:0]  o_tx_request;
    logic [63:0] o_config;
    wire logic [1:0] i_can_rx = {2{rx_lvl}};
    wire logic [1:0] i_bit_tick = {2{tick_b}};
    wire logic [1:0] i_bus_idle = {2{idle}};
    int fails = 0, total_checks = 0, n_tx0 = 0, n_tx1 = 0, n_rx = 0, n_err = 0;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d, m, e;} cevp_row_t;
    cevp_row_t rows [7] = '{
        '{8'h00, 1'b0, 32'h0, 32'h1, 32'h1},        // init set after reset
        '{8'h04, 1'b0, 32'h0, 32'h1F, 32'h0},
        '{8'h08, 1'b0, 32'h0, 32'hF, 32'h0},
        '{8'h14, 1'b0, 32'h0, 32'hFFFF, 32'h0},
        '{8'h20, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h0}, // unmapped place
        '{8'h18, 1'b1, 32'hAB, 32'hFFFFFFFF, 32'hAB},
        '{8'h4C, 1'b1, 32'h5, 32'hFFFF, 32'h5}};

    always #2 i_ref_clk = ~i_ref_clk;

    cevp_top cevp_top_inst (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_can_rx, .i_bit_tick, .i_bus_idle, .i_clk_restart, .i_init_active, .i_tx_done,
        .i_err_state, .i_overrun, .i_frame_valid, .i_id_match, .i_match_buf, .i_store_start,
        .i_store_done, .o_err_irq, .o_rx_irq, .o_tx0_irq, .o_tx1_irq, .o_tx_request,
        .o_online, .o_config);
    cevp_bus_model cevp_bus_model_inst (.i_ref_clk, .i_dominant(dom), .o_can_rx(rx_lvl),
        .o_bit_tick(tick_b), .o_bus_idle(idle));

    always @(posedge i_ref_clk) begin
        if (o_tx0_irq[0] === 1'b1) n_tx0++;
        if (o_tx1_irq[0] === 1'b1) n_tx1++;
        if (o_rx_irq[0] === 1'b1) n_rx++;
        if (o_err_irq[0] === 1'b1) n_err++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(negedge i_ref_clk);
        chk(o_rdata & m, e);
        @(posedge i_ref_clk);
    endtask
    task automatic store(input logic [7:0] b, input logic [31:0] mid);
        @(posedge i_ref_clk);
        i_match_buf <= b;
        i_store_start <= 2'h1;
        @(posedge i_ref_clk);
        i_store_start <= 2'h0;
        rd_chk(8'h14, 32'hFFFF, mid);
        @(posedge i_ref_clk);
        i_store_done <= 2'h1;
        @(posedge i_ref_clk);
        i_store_done <= 2'h0;
        tick(2);
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: tests need about 310 cycles
    initial begin
        #40000;
        fails++;
        give_verdict();
    end

    initial begin
        tick(12);
        i_srst <= 1'b0;
        tick(4);
        i_init_active <= 2'h2;
        wr_reg(8'h18, 32'h77);
        rd_chk(8'h18, 32'hFFFFFFFF, 32'h0);
        i_init_active <= 2'h3;
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].m, rows[i].e);
        end
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h18, 32'h55);
        rd_chk(8'h18, 32'hFFFFFFFF, 32'hAB);
        chk({31'h0, o_online[0]}, 32'h1);
        $display("register tests done");
        wr_reg(8'h08, 32'h3);
        tick(2);
        chk({28'h0, o_tx_request}, 32'h3);
        @(posedge i_ref_clk);
        i_tx_done <= 4'h1;
        @(posedge i_ref_clk);
        i_tx_done <= 4'h0;
        wr_reg(8'h08, 32'h8);
        wr_reg(8'h08, 32'h4);
        tick(4);
        chk({28'h0, o_tx_request}, 32'h0);
        chk(n_tx0, 32'h1);
        chk(n_tx1, 32'h1);
        $display("transmit tests done");
        wr_reg(8'h0C, 32'h4);
        store(8'h02, 32'h4);
        store(8'h03, 32'h8);
        i_frame_valid <= 2'h0;
        store(8'h01, 32'h0);
        rd_chk(8'h10, 32'hFFFF, 32'hC);
        rd_chk(8'h14, 32'hFFFF, 32'h0);
        chk(n_rx, 32'h1);
        wr_reg(8'h10, 32'hC);
        rd_chk(8'h10, 32'hFFFF, 32'h0);
        rd_chk(8'h14, 32'hFFFF, 32'h0);
        $display("receive tests done");
        i_err_state <= 8'h01;
        tick(4);
        @(posedge i_ref_clk);
        i_clk_restart <= 2'h1;
        @(posedge i_ref_clk);
        i_clk_restart <= 2'h0;
        rd_chk(8'h04, 32'hF, 32'h9);
        chk(n_err, 32'h2);
        $display("error tests done");
        wr_reg(8'h00, 32'h2);
        tick(4);
        rd_chk(8'h00, 32'hF0, 32'h20);
        rd_chk(8'h04, 32'h10, 32'h0);
        dom <= 1'b1;
        tick(8);
        rd_chk(8'h04, 32'h10, 32'h10);
        rd_chk(8'h00, 32'hF0, 32'h80);
        dom <= 1'b0;
        tick(60);
        rd_chk(8'h00, 32'hF0, 32'h10);
        chk({31'h0, o_err_irq[0]}, 32'h1);
        wr_reg(8'h04, 32'h10);
        tick(2);
        chk({31'h0, o_err_irq[0]}, 32'h0);
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h00, 32'h6);
        tick(4);
        rd_chk(8'h00, 32'hF0, 32'h40);
        dom <= 1'b1;
        tick(10);
        rd_chk(8'h00, 32'hF0, 32'h40);
        dom <= 1'b0;
        wr_reg(8'h00, 32'h0);
        tick(60);
        rd_chk(8'h00, 32'hF0, 32'h10);
        dom <= 1'b1;
        wr_reg(8'h00, 32'h2);
        tick(4);
        rd_chk(8'h04, 32'h10, 32'h10);
        rd_chk(8'h00, 32'hF0, 32'h10);
        $display("power tests done");
        give_verdict();
    end
endmodule // testbench
